/* inc/smfd_regs.vh */
// Register map, field positions, reset values and state codes of the FIFO/DMA path
`ifndef SMFD_REGS_VH
`define SMFD_REGS_VH
`define SMFD_OFS_PUSH     8'h00
`define SMFD_OFS_POP      8'h04
`define SMFD_OFS_CTRL     8'h08
`define SMFD_OFS_LOC      8'h0c
`define SMFD_OFS_THR      8'h10
`define SMFD_OFS_DMACFG   8'h14
`define SMFD_OFS_TRIG     8'h18
`define SMFD_OFS_DLEFT    8'h1c
`define SMFD_OFS_DADDR    8'h20
`define SMFD_OFS_CMD      8'h24
`define SMFD_OFS_STATE    8'h28
`define SMFD_AP_WFIFO     3'h2
`define SMFD_AP_RFIFO     3'h3
`define SMFD_CTRL_POP_REQUIRES_WRITE   0
`define SMFD_CTRL_PRSTN   1
`define SMFD_CTRL_RESET   2'h2
`define SMFD_THR_RD_LSB   0
`define SMFD_THR_WR_LSB   8
`define SMFD_THR_RESET    6'h10
`define SMFD_DCFG_EN      0
`define SMFD_DCFG_M2P     1
`define SMFD_TRIG_CMP     0
`define SMFD_TRIG_THR     1
`define SMFD_CMD_WRITE    12
`define SMFD_CMD_I2C      13
`define SMFD_I2C_MAX      12'h200
`define SMFD_FIFO_BYTES   6'h20
`define SMFD_CST_IDLE     3'h0
`define SMFD_CST_ACTIVE   3'h2
`define SMFD_CST_WAIT     3'h6
`define SMFD_DST_IDLE     1'b0
`define SMFD_DST_XFER     1'b1
`endif

/* rtl/smfd_fifo_dma.v */
// Data FIFOs, direct push/pop ports and DMA engine of the serial master unit
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "smfd_regs.vh"

module smfd_fifo_dma (
    input  wire        ref_clk_in,
    input  wire        rstn_in,
    input  wire [7:0]  bus_addr_in,
    input  wire [31:0] bus_wdata_in,
    input  wire        bus_wr_in,
    input  wire        bus_rd_in,
    output reg  [31:0] bus_rdata_out,
    input  wire        eng_tx_take_in,
    input  wire        eng_rx_put_in,
    input  wire [7:0]  eng_rx_byte_in,
    output reg         eng_cmd_active_out,
    output reg         eng_cmd_write_out,
    output reg         eng_cmd_done_out,
    output reg  [7:0]  eng_tx_byte_out,
    output reg         eng_tx_avail_out,
    output reg         eng_rx_room_out,
    output reg         eng_pause_out,
    output reg         mem_req_out,
    output reg         mem_we_out,
    output reg  [31:0] mem_addr_out,
    output reg  [7:0]  mem_wdata_out,
    input  wire [7:0]  mem_rdata_in,
    input  wire        mem_ack_in
);

    // ----------------------------------------
    // Byte lane helpers
    // ----------------------------------------
    // Lane 0 write clears the word, so a partial tail word reads zero
    function [31:0] smfd_put;
        input [31:0] w;
        input [1:0]  lane;
        input [7:0]  b;
        begin
            case (lane)
                2'h0:    smfd_put = {24'h0, b};
                2'h1:    smfd_put = {w[31:16], b, w[7:0]};
                2'h2:    smfd_put = {w[31:24], b, w[15:0]};
                default: smfd_put = {b, w[23:0]};
            endcase
        end
    endfunction

    function [7:0] smfd_get;
        input [31:0] w;
        input [1:0]  lane;
        begin
            case (lane)
                2'h0:    smfd_get = w[7:0];
                2'h1:    smfd_get = w[15:8];
                2'h2:    smfd_get = w[23:16];
                default: smfd_get = w[31:24];
            endcase
        end
    endfunction

    function [11:0] smfd_min;
        input [11:0] a;
        input [11:0] b;
        begin
            smfd_min = (a < b) ? a : b;
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg  [1:0]  rst_sync_reg;
    wire        rst_n = rst_sync_reg[1];

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [31:0] wmem [0:7];
    reg  [31:0] rmem [0:7];
    reg  [4:0]  wptr_reg;
    reg  [4:0]  weptr_reg;
    reg  [5:0]  wcnt_reg;
    reg  [4:0]  reptr_reg;
    reg  [4:0]  rptr_reg;
    reg  [5:0]  rcnt_reg;
    reg  [1:0]  ctrl_reg;
    reg  [5:0]  thr_rd_reg;
    reg  [5:0]  thr_wr_reg;
    reg         dma_en_reg;
    reg         dma_m2p_reg;
    reg         trig_cmp_reg;
    reg         trig_thr_reg;
    reg  [11:0] dma_left_reg;
    reg  [11:0] burst_reg;
    reg         cmp_pend_reg;
    reg         dma_state_reg;
    reg  [11:0] cmd_left_reg;
    reg  [2:0]  cmd_state_reg;
    integer     i;

    wire        pop_requires_write = ctrl_reg[`SMFD_CTRL_POP_REQUIRES_WRITE];
    wire        prstn = ctrl_reg[`SMFD_CTRL_PRSTN];
    wire        ap_w  = bus_addr_in[7:5] == `SMFD_AP_WFIFO;
    wire        ap_r  = bus_addr_in[7:5] == `SMFD_AP_RFIFO;
    wire        dma_busy = dma_en_reg || (dma_state_reg == `SMFD_DST_XFER);

    // ----------------------------------------
    // Direct port and engine events
    // ----------------------------------------
    // Direct ports only while DMA is off; mixing would corrupt DMA data
    wire push   = bus_wr_in && bus_addr_in == `SMFD_OFS_PUSH && !dma_busy
                  && wcnt_reg <= 6'h1c;
    wire pop_ad = bus_addr_in == `SMFD_OFS_POP && !dma_busy && rcnt_reg != 6'h0;
    wire pop    = pop_ad && (pop_requires_write ? bus_wr_in : bus_rd_in);
    wire tx_take = eng_tx_take_in && eng_tx_avail_out && eng_cmd_active_out
                   && eng_cmd_write_out;
    wire rx_put  = eng_rx_put_in && eng_rx_room_out && eng_cmd_active_out
                   && !eng_cmd_write_out;
    wire dma_ack = (dma_state_reg == `SMFD_DST_XFER) && mem_ack_in;
    wire dma_w   = dma_ack && dma_m2p_reg;
    wire dma_r   = dma_ack && !dma_m2p_reg;

    // ----------------------------------------
    // Command tracking
    // ----------------------------------------
    wire        cmd_go   = bus_wr_in && bus_addr_in == `SMFD_OFS_CMD && !eng_cmd_active_out;
    wire [11:0] cmd_raw  = bus_wdata_in[11:0];
    wire [11:0] cmd_sz   = (bus_wdata_in[`SMFD_CMD_I2C] && cmd_raw > `SMFD_I2C_MAX) ?
                           `SMFD_I2C_MAX : cmd_raw;
    wire        cmd_wr_n = cmd_go ? bus_wdata_in[`SMFD_CMD_WRITE] : eng_cmd_write_out;
    wire        done_now = (cmd_go && cmd_sz == 12'h0)
                           || ((tx_take || rx_put) && cmd_left_reg == 12'h1);
    wire        act_next = cmd_go ? (cmd_sz != 12'h0) :
                           (done_now ? 1'b0 : eng_cmd_active_out);
    wire        wdone    = done_now && cmd_wr_n;
    wire        rdone    = done_now && !cmd_wr_n;

    // ----------------------------------------
    // Write FIFO arithmetic
    // ----------------------------------------
    // Tail bytes of the last word are skipped to the next word
    wire [4:0]  weptr_t = weptr_reg + {4'h0, tx_take};
    wire [2:0]  wskip   = (wdone && weptr_t[1:0] != 2'h0) ?
                          (3'h4 - {1'b0, weptr_t[1:0]}) : 3'h0;
    wire [4:0]  weptr_n = weptr_t + {2'h0, wskip};
    wire [6:0]  wsum    = {1'b0, wcnt_reg} + (push ? 7'h4 : 7'h0) + {6'h0, dma_w}
                          - {6'h0, tx_take} - {4'h0, wskip};
    wire [5:0]  wcnt_n  = prstn ? wsum[5:0] : 6'h0;
    wire [4:0]  wptr_n  = push ? {wptr_reg[4:2] + 3'h1, 2'h0} :
                          (dma_w ? wptr_reg + 5'h1 : wptr_reg);
    wire        apw_we  = bus_wr_in && ap_w && !dma_w;
    wire        wm_we   = push || dma_w || apw_we;
    wire [2:0]  wm_idx  = apw_we ? bus_addr_in[4:2] : wptr_reg[2+:3];
    wire [31:0] wm_dat  = dma_w ? smfd_put(wmem[wptr_reg[4:2]], wptr_reg[1:0], mem_rdata_in)
                          : bus_wdata_in;

    // ----------------------------------------
    // Read FIFO arithmetic
    // ----------------------------------------
    // Zero-filled tail counts as data so pops stay word aligned
    wire [4:0]  reptr_t = reptr_reg + {4'h0, rx_put};
    wire [2:0]  rfill   = (rdone && reptr_t[1:0] != 2'h0) ?
                          (3'h4 - {1'b0, reptr_t[1:0]}) : 3'h0;
    wire [4:0]  reptr_n = reptr_t + {2'h0, rfill};
    wire [2:0]  popdec  = !pop ? 3'h0 : (rcnt_reg >= 6'h4 ? 3'h4 : rcnt_reg[2:0]);
    wire [6:0]  rsum    = {1'b0, rcnt_reg} + {6'h0, rx_put} + {4'h0, rfill}
                          - {4'h0, popdec} - {6'h0, dma_r};
    wire [5:0]  rcnt_n  = prstn ? rsum[5:0] : 6'h0;
    wire [4:0]  rptr_n  = !prstn ? 5'h0 :
                          (pop ? {rptr_reg[4:2] + 3'h1, 2'h0} :
                          (dma_r ? rptr_reg + 5'h1 : rptr_reg));

    // ----------------------------------------
    // DMA triggers
    // ----------------------------------------
    // Only the word count of each threshold is compared
    wire [5:0]  wfree  = `SMFD_FIFO_BYTES - wcnt_reg;
    wire [3:0]  wt_eff = (thr_wr_reg[5:2] == 4'h0) ? 4'h1 : thr_wr_reg[5:2];
    wire [3:0]  rt_eff = (thr_rd_reg[5:2] == 4'h0) ? 4'h1 : thr_rd_reg[5:2];
    wire        dbase  = dma_en_reg && dma_state_reg == `SMFD_DST_IDLE
                         && dma_left_reg != 12'h0;
    wire        t_w    = dbase && dma_m2p_reg && trig_thr_reg
                         && wfree[5:2] >= wt_eff;
    wire        t_r    = dbase && !dma_m2p_reg && trig_thr_reg
                         && rcnt_reg[5:2] >= rt_eff;
    wire        t_rest = dbase && !dma_m2p_reg && trig_thr_reg && !trig_cmp_reg
                         && rcnt_reg != 6'h0 && {6'h0, rcnt_reg} >= dma_left_reg;
    wire        t_cmp  = dbase && !dma_m2p_reg && trig_cmp_reg && cmp_pend_reg;
    wire        cmp_take = t_cmp && !t_r && !t_rest;
    wire [11:0] dlen   = t_w ? smfd_min(dma_left_reg, {6'h0, wt_eff, 2'h0}) :
                         t_r ? smfd_min(dma_left_reg, {6'h0, rt_eff, 2'h0}) :
                         t_rest ? dma_left_reg :
                         smfd_min(dma_left_reg, {6'h0, rcnt_reg});
    wire        dstart = (t_w || t_r || t_rest || t_cmp) && dlen != 12'h0;

    // Stall looks at next-state counts so outputs never lag a change
    wire        stall_n = cmd_wr_n ? (wcnt_n == 6'h0) : (rcnt_n == `SMFD_FIFO_BYTES);
    wire        wm_hit  = wm_we && wm_idx == weptr_n[4:2];

    // ----------------------------------------
    // FIFO memories
    // ----------------------------------------
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                wmem[i] <= 32'h0;
                rmem[i] <= 32'h0;
            end
        end else begin
            if (wm_we) begin
                wmem[wm_idx] <= wm_dat;
            end
            if (rx_put) begin
                rmem[reptr_reg[4:2]] <= smfd_put(rmem[reptr_reg[4:2]], reptr_reg[1:0],
                                                 eng_rx_byte_in);
            end
        end
    end

    // ----------------------------------------
    // Pointers, command and engine outputs
    // ----------------------------------------
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg           <= 5'h0;
            weptr_reg          <= 5'h0;
            wcnt_reg           <= 6'h0;
            reptr_reg          <= 5'h0;
            rptr_reg           <= 5'h0;
            rcnt_reg           <= 6'h0;
            cmd_left_reg       <= 12'h0;
            cmd_state_reg      <= `SMFD_CST_IDLE;
            eng_cmd_active_out <= 1'b0;
            eng_cmd_write_out  <= 1'b0;
            eng_cmd_done_out   <= 1'b0;
            eng_tx_byte_out    <= 8'h0;
            eng_tx_avail_out   <= 1'b0;
            eng_rx_room_out    <= 1'b0;
            eng_pause_out      <= 1'b0;
        end else begin
            wptr_reg  <= prstn ? wptr_n : 5'h0;
            weptr_reg <= prstn ? weptr_n : 5'h0;
            reptr_reg <= prstn ? reptr_n : 5'h0;
            rptr_reg  <= rptr_n;
            wcnt_reg  <= wcnt_n;
            rcnt_reg  <= rcnt_n;
            if (cmd_go) begin
                cmd_left_reg <= cmd_sz;
            end else if (tx_take || rx_put) begin
                cmd_left_reg <= cmd_left_reg - 12'h1;
            end
            eng_cmd_active_out <= act_next;
            eng_cmd_write_out  <= cmd_wr_n;
            eng_cmd_done_out   <= done_now;
            // Fresh word written at the next slot waits a cycle for its data
            eng_tx_byte_out    <= smfd_get(wmem[weptr_n[4:2]], weptr_n[1:0]);
            eng_tx_avail_out   <= wcnt_n != 6'h0 && !wm_hit;
            eng_rx_room_out    <= rcnt_n != `SMFD_FIFO_BYTES;
            eng_pause_out      <= act_next && stall_n;
            cmd_state_reg      <= !act_next ? `SMFD_CST_IDLE :
                                  (stall_n ? `SMFD_CST_WAIT : `SMFD_CST_ACTIVE);
        end
    end

    // ----------------------------------------
    // Control registers and DMA engine
    // ----------------------------------------
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg      <= `SMFD_CTRL_RESET;
            thr_rd_reg    <= `SMFD_THR_RESET;
            thr_wr_reg    <= `SMFD_THR_RESET;
            dma_en_reg    <= 1'b0;
            dma_m2p_reg   <= 1'b0;
            trig_cmp_reg  <= 1'b0;
            trig_thr_reg  <= 1'b0;
            dma_left_reg  <= 12'h0;
            burst_reg     <= 12'h0;
            cmp_pend_reg  <= 1'b0;
            dma_state_reg <= `SMFD_DST_IDLE;
            mem_req_out   <= 1'b0;
            mem_we_out    <= 1'b0;
            mem_addr_out  <= 32'h0;
            mem_wdata_out <= 8'h0;
        end else begin
            if (bus_wr_in) begin
                case (bus_addr_in)
                    `SMFD_OFS_CTRL: begin
                        ctrl_reg <= bus_wdata_in[1:0];
                    end
                    `SMFD_OFS_THR: begin
                        thr_rd_reg <= bus_wdata_in[`SMFD_THR_RD_LSB+:6];
                        thr_wr_reg <= bus_wdata_in[`SMFD_THR_WR_LSB+:6];
                    end
                    `SMFD_OFS_DMACFG: begin
                        dma_en_reg  <= bus_wdata_in[`SMFD_DCFG_EN];
                        dma_m2p_reg <= bus_wdata_in[`SMFD_DCFG_M2P];
                    end
                    `SMFD_OFS_TRIG: begin
                        trig_cmp_reg <= bus_wdata_in[`SMFD_TRIG_CMP];
                        trig_thr_reg <= bus_wdata_in[`SMFD_TRIG_THR];
                    end
                    default: begin
                    end
                endcase
            end
            // Completion arriving as the pending flag is taken is kept
            if (rdone) begin
                cmp_pend_reg <= 1'b1;
            end else if (cmp_take) begin
                cmp_pend_reg <= 1'b0;
            end
            // Software count and address writes win over the engine's own update
            if (bus_wr_in && bus_addr_in == `SMFD_OFS_DLEFT) begin
                dma_left_reg <= bus_wdata_in[11:0];
            end else if (dma_ack) begin
                dma_left_reg <= dma_left_reg - 12'h1;
            end
            if (bus_wr_in && bus_addr_in == `SMFD_OFS_DADDR) begin
                mem_addr_out <= bus_wdata_in;
            end else if (dma_ack) begin
                mem_addr_out <= mem_addr_out + 32'h1;
            end
            case (dma_state_reg)
                `SMFD_DST_IDLE: begin
                    if (dstart) begin
                        dma_state_reg <= `SMFD_DST_XFER;
                        burst_reg     <= dlen;
                        mem_req_out   <= 1'b1;
                        mem_we_out    <= !dma_m2p_reg;
                        mem_wdata_out <= smfd_get(rmem[rptr_reg[4:2]], rptr_reg[1:0]);
                    end
                end
                `SMFD_DST_XFER: begin
                    if (mem_ack_in) begin
                        burst_reg     <= burst_reg - 12'h1;
                        mem_wdata_out <= smfd_get(rmem[rptr_n[4:2]], rptr_n[1:0]);
                        if (burst_reg == 12'h1) begin
                            dma_state_reg <= `SMFD_DST_IDLE;
                            mem_req_out   <= 1'b0;
                        end
                    end
                end
                default: begin
                    dma_state_reg <= `SMFD_DST_IDLE;
                    mem_req_out   <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata_out <= 32'h0;
        end else if (!bus_rd_in) begin
            bus_rdata_out <= 32'h0;
        end else if (ap_w) begin
            bus_rdata_out <= wmem[bus_addr_in[4:2]];
        end else if (ap_r) begin
            bus_rdata_out <= rmem[bus_addr_in[4:2]];
        end else begin
            case (bus_addr_in)
                `SMFD_OFS_POP:    bus_rdata_out <= rmem[rptr_reg[4:2]];
                `SMFD_OFS_CTRL:   bus_rdata_out <= {30'h0, ctrl_reg};
                `SMFD_OFS_LOC:    bus_rdata_out <= {2'h0, rcnt_reg, 2'h0, wcnt_reg,
                                                    3'h0, rptr_reg, 3'h0, wptr_reg};
                `SMFD_OFS_THR:    bus_rdata_out <= {18'h0, thr_wr_reg, 2'h0, thr_rd_reg};
                `SMFD_OFS_DMACFG: bus_rdata_out <= {30'h0, dma_m2p_reg, dma_en_reg};
                `SMFD_OFS_TRIG:   bus_rdata_out <= {30'h0, trig_thr_reg, trig_cmp_reg};
                `SMFD_OFS_DLEFT:  bus_rdata_out <= {20'h0, dma_left_reg};
                `SMFD_OFS_DADDR:  bus_rdata_out <= mem_addr_out;
                `SMFD_OFS_CMD:    bus_rdata_out <= {19'h0, eng_cmd_write_out, cmd_left_reg};
                `SMFD_OFS_STATE:  bus_rdata_out <= {29'h0, cmd_state_reg};
                default:          bus_rdata_out <= 32'h0;
            endcase
        end
    end

endmodule
`default_nettype wire

/* tb/smfd_fifo_dma_sva.sv */
// Port assertions for the FIFO/DMA path
`timescale 1ns/1ps
`default_nettype none
`include "smfd_regs.vh"
module smfd_fifo_dma_sva (
    input wire logic        ref_clk_in,
    input wire logic        rstn_in,
    input wire logic [7:0]  bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic        bus_wr_in,
    input wire logic        bus_rd_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic        eng_cmd_active_out,
    input wire logic        eng_cmd_write_out,
    input wire logic        eng_cmd_done_out,
    input wire logic        eng_tx_avail_out,
    input wire logic        eng_rx_room_out,
    input wire logic        eng_pause_out,
    input wire logic        mem_req_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic        mem_ack_in
);
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // ----
    // Checks
    // ----
    rdata_idle_a: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 32'h0)
        else $error("read data outside its slot");
    pause_cause_a: assert property (eng_pause_out |-> eng_cmd_active_out &&
        !(eng_cmd_write_out ? eng_tx_avail_out : eng_rx_room_out))
        else $error("pause without cause");
    done_pulse_a: assert property (eng_cmd_done_out |=> !eng_cmd_done_out)
        else $error("done longer than one cycle");
    done_ends_a: assert property (eng_cmd_done_out |-> ##[0:1] !eng_cmd_active_out)
        else $error("command active after done");
    req_hold_a: assert property (mem_req_out && !mem_ack_in |=>
        mem_req_out && $stable(mem_addr_out))
        else $error("memory request dropped early");
    addr_step_a: assert property (mem_req_out && mem_ack_in |=>
        !mem_req_out || mem_addr_out == $past(mem_addr_out) + 32'h1)
        else $error("address did not step one byte");
    zero_cmd_a: assert property (bus_wr_in && bus_addr_in == `SMFD_OFS_CMD &&
        !eng_cmd_active_out && bus_wdata_in[11:0] == 12'h0 |-> ##[1:2] eng_cmd_done_out)
        else $error("empty command gave no done");
    cmd_start_a: assert property (bus_wr_in && bus_addr_in == `SMFD_OFS_CMD &&
        !eng_cmd_active_out && bus_wdata_in[11:0] != 12'h0 |=> eng_cmd_active_out &&
        eng_cmd_write_out == $past(bus_wdata_in[`SMFD_CMD_WRITE]))
        else $error("command did not start");
endmodule
bind smfd_fifo_dma smfd_fifo_dma_sva u_sva (.*);
`default_nettype wire

/* tb/smfd_mem_model.sv */
// Byte-wide system memory answering DMA requests after a set wait
`timescale 1ns/1ps
`default_nettype none
module smfd_mem_model (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic [1:0]  dly_in,
    output var  logic [7:0]  rdata_out = 8'h00,
    output var  logic        ack_out = 1'b0
);
    logic [7:0] mem [0:255];
    logic [1:0] wait_reg = 2'h0;
    // ----
    // Answer
    // ----
    initial for (int j = 0; j < 256; j++) mem[j] = 8'(j) ^ 8'h5a;
    // Data toggles when idle so a stale byte never passes as an answer
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out && wait_reg == dly_in) begin
            ack_out <= 1'b1;
            wait_reg <= 2'h0;
            rdata_out <= mem[addr_in[7:0]];
            if (we_in)
                mem[addr_in[7:0]] <= wdata_in;
        end else if (req_in && !ack_out)
            wait_reg <= wait_reg + 2'h1;
    end
endmodule
`default_nettype wire

/* tb/smfd_fifo_dma_tb_top.sv */
// Self-checking bench for the FIFO/DMA path
`timescale 1ns/1ps
`default_nettype none
`include "smfd_regs.vh"
module smfd_fifo_dma_tb_top;
    logic        ref_clk_in = 1'b0, rstn_in = 1'b0, bus_wr_in = 1'b0, bus_rd_in = 1'b0;
    logic        eng_tx_take_in = 1'b0, eng_rx_put_in = 1'b0;
    logic [7:0]  bus_addr_in = 8'h00, eng_rx_byte_in = 8'h00;
    logic [31:0] bus_wdata_in = 32'h0, bus_rdata_out, mem_addr_out, q;
    logic [7:0]  eng_tx_byte_out, mem_wdata_out, mem_rdata_in;
    logic        eng_cmd_active_out, eng_cmd_write_out, eng_cmd_done_out, eng_tx_avail_out;
    logic        eng_rx_room_out, eng_pause_out, mem_req_out, mem_we_out, mem_ack_in;
    logic [1:0]  mem_dly = 2'h0;
    int          n_fail = 0, total_checks = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    smfd_fifo_dma DUT (.*);
    smfd_mem_model u_mem (.clk_in(ref_clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
        .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .dly_in(mem_dly),
        .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
    // ----
    // Bus and engine tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        bus_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        bus_rd_in <= 1'b0;
        #1 q = bus_rdata_out;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(q, e);
    endtask
    // Waits bounded, so a stuck engine shows up as a failed avail/room flag check
    task automatic eng(input logic tx, input logic [7:0] b);
        #1;
        for (int k = 0; k < 40 && (tx ? eng_tx_avail_out : eng_rx_room_out) !== 1'b1; k++)
            @(posedge ref_clk_in) #1;
        chk(tx ? eng_tx_avail_out : eng_rx_room_out, 1'b1);
        if (tx)
            chk(eng_tx_byte_out, b);
        @(posedge ref_clk_in);
        eng_tx_take_in <= tx;
        eng_rx_put_in <= !tx;
        eng_rx_byte_in <= b;
        @(posedge ref_clk_in);
        eng_tx_take_in <= 1'b0;
        eng_rx_put_in <= 1'b0;
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rc(`SMFD_OFS_CTRL, 32'h2);
        rc(`SMFD_OFS_THR, 32'h1010);
        wr(8'h40, 32'hcafe0001);
        rc(8'h40, 32'hcafe0001);
        rc(`SMFD_OFS_LOC, 32'h0);
        rc(8'h30, 32'h0);
    endtask
    task automatic t_write;
        wr(`SMFD_OFS_CMD, 32'h1004);
        rc(`SMFD_OFS_STATE, 32'h6);
        chk(eng_pause_out, 1'b1);
        wr(`SMFD_OFS_PUSH, 32'h44332211);
        for (int j = 0; j < 4; j++) eng(1'b1, 8'(8'h11 * (j + 1)));
        repeat (3) @(posedge ref_clk_in);
        wr(`SMFD_OFS_CMD, 32'h0);
        wr(`SMFD_OFS_PUSH, 32'hddccbbaa);
        wr(`SMFD_OFS_PUSH, 32'h998877ee);
        rc(`SMFD_OFS_LOC, 32'h0008000c);
        wr(`SMFD_OFS_CMD, 32'h1005);
        for (int j = 0; j < 5; j++) eng(1'b1, 8'haa + 8'(j) * 8'h11);
        repeat (3) @(posedge ref_clk_in);
        rc(`SMFD_OFS_LOC, 32'h0000000c);
    endtask
    task automatic t_read;
        wr(`SMFD_OFS_CMD, 32'h5);
        for (int j = 0; j < 5; j++) eng(1'b0, 8'h61 + 8'(j));
        repeat (3) @(posedge ref_clk_in);
        rc(`SMFD_OFS_LOC, 32'h0800000c);
        rc(`SMFD_OFS_POP, 32'h64636261);
        wr(`SMFD_OFS_CTRL, 32'h3);
        rc(`SMFD_OFS_POP, 32'h00000065);
        rc(`SMFD_OFS_POP, 32'h00000065);
        wr(`SMFD_OFS_POP, 32'h0);
        rc(`SMFD_OFS_LOC, 32'h0000080c);
        wr(`SMFD_OFS_CTRL, 32'h0);
        wr(`SMFD_OFS_CTRL, 32'h2);
        rc(`SMFD_OFS_LOC, 32'h0);
    endtask
    task automatic t_dma;
        mem_dly <= 2'h2;
        wr(`SMFD_OFS_DADDR, 32'h3);
        wr(`SMFD_OFS_DLEFT, 32'h6);
        wr(`SMFD_OFS_TRIG, 32'h2);
        wr(`SMFD_OFS_DMACFG, 32'h3);
        q = 32'h1;
        for (int j = 0; j < 40 && q !== 32'h0; j++) rd(`SMFD_OFS_DLEFT);
        rc(`SMFD_OFS_DLEFT, 32'h0);
        chk(mem_req_out, 1'b0);
        wr(`SMFD_OFS_DMACFG, 32'h0);
        wr(`SMFD_OFS_CMD, 32'h1006);
        for (int j = 3; j < 9; j++) eng(1'b1, 8'(j) ^ 8'h5a);
    endtask
    // Read command drained to memory by the completion trigger
    task automatic t_p2m;
        wr(`SMFD_OFS_DLEFT, 32'h1fff);
        rc(`SMFD_OFS_DLEFT, 32'h00000fff);
        wr(`SMFD_OFS_DLEFT, 32'h3);
        wr(`SMFD_OFS_DADDR, 32'h10);
        wr(`SMFD_OFS_TRIG, 32'h1);
        wr(`SMFD_OFS_DMACFG, 32'h1);
        wr(`SMFD_OFS_CMD, 32'h3);
        for (int j = 0; j < 3; j++) eng(1'b0, 8'ha1 + 8'(j));
        q = 32'h1;
        for (int j = 0; j < 40 && q !== 32'h0; j++) rd(`SMFD_OFS_DLEFT);
        rc(`SMFD_OFS_DLEFT, 32'h0);
        for (int j = 0; j < 3; j++) chk(u_mem.mem[8'h10 + j], 32'ha1 + j);
        chk(u_mem.mem[8'h13], 32'h49);
        wr(`SMFD_OFS_DMACFG, 32'h0);
        wr(`SMFD_OFS_CMD, 32'h2fff);
        rc(`SMFD_OFS_CMD, 32'h00000200);
        rc(`SMFD_OFS_STATE, 32'h2);
    endtask
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        t_reset();
        t_write();
        t_read();
        t_dma();
        t_p2m();
        end_of_test();
    end
endmodule
`default_nettype wire
